/* File: ltpg_pkg.sv */
// ltpg_pkg: constants for the link test pattern generator.
// assumes one converter clock domain; register port driven by the serial config core.
package ltpg_pkg;

   // register addresses
   localparam logic [15:0] LTPG_ADDR_CTRL = 16'h0573; // pattern control register
   localparam logic [15:0] LTPG_ADDR_UP_FIRST = 16'h0551; // first user pattern byte
   localparam logic [15:0] LTPG_ADDR_UP_LAST = 16'h0558; // last user pattern byte
   localparam logic [7:0] LTPG_CTRL_RESET = 8'h00; // control value after reset
   localparam int LTPG_MODE_LSB = 0; // mode field position
   localparam int LTPG_INJ_LSB = 4; // injection field position
   localparam int LTPG_UP_BYTES = 8; // four 16-bit user words

   // pattern modes
   localparam logic [3:0] LTPG_MODE_OFF = 4'h0;
   localparam logic [3:0] LTPG_MODE_CHECKER = 4'h1;
   localparam logic [3:0] LTPG_MODE_TOGGLE = 4'h2;
   localparam logic [3:0] LTPG_MODE_PN31 = 4'h3;
   localparam logic [3:0] LTPG_MODE_PN23 = 4'h4;
   localparam logic [3:0] LTPG_MODE_PN15 = 4'h5;
   localparam logic [3:0] LTPG_MODE_PN9 = 4'h6;
   localparam logic [3:0] LTPG_MODE_PN7 = 4'h7;
   localparam logic [3:0] LTPG_MODE_RAMP = 4'h8;
   localparam logic [3:0] LTPG_MODE_UP_REPEAT = 4'hE;
   localparam logic [3:0] LTPG_MODE_UP_SINGLE = 4'hF;

   // injection points
   localparam logic [1:0] LTPG_INJ_SAMPLE = 2'h0;
   localparam logic [1:0] LTPG_INJ_SYMBOL = 2'h1;
   localparam logic [1:0] LTPG_INJ_OCTET = 2'h2;

   // widths of each injection point, and user word slice positions
   localparam int LTPG_DATA_W = 16;
   localparam logic [4:0] LTPG_W_SAMPLE = 5'h10;
   localparam logic [4:0] LTPG_W_SYMBOL = 5'h0A;
   localparam logic [4:0] LTPG_W_OCTET = 5'h08;
   localparam int LTPG_UP_SYMBOL_LSB = 6;
   localparam int LTPG_UP_OCTET_LSB = 8;

   // fixed pattern words
   localparam logic [15:0] LTPG_CHECK_A = 16'h5555;
   localparam logic [15:0] LTPG_CHECK_B = 16'hAAAA;
   localparam logic [15:0] LTPG_TOGGLE_HI = 16'hFFFF;

   // pseudorandom seeds, lengths and taps
   localparam logic [30:0] LTPG_SEED_PN31 = 31'h0003AFFF;
   localparam logic [30:0] LTPG_SEED_PN23 = 31'h0000_3AFF;
   localparam logic [30:0] LTPG_SEED_PN15 = 31'h0000_03AF;
   localparam logic [30:0] LTPG_SEED_PN9 = 31'h0000_0092;
   localparam logic [30:0] LTPG_SEED_PN7 = 31'h0000_0007;
   localparam logic [4:0] LTPG_LEN_PN31 = 5'h1F;
   localparam logic [4:0] LTPG_TAP_PN31 = 5'h1C;
   localparam logic [4:0] LTPG_LEN_PN23 = 5'h17;
   localparam logic [4:0] LTPG_TAP_PN23 = 5'h12;
   localparam logic [4:0] LTPG_LEN_PN15 = 5'h0F;
   localparam logic [4:0] LTPG_TAP_PN15 = 5'h0E;
   localparam logic [4:0] LTPG_LEN_PN9 = 5'h09;
   localparam logic [4:0] LTPG_TAP_PN9 = 5'h05;
   localparam logic [4:0] LTPG_LEN_PN7 = 5'h07;
   localparam logic [4:0] LTPG_TAP_PN7 = 5'h06;

   localparam int LTPG_FIFO_DEPTH = 16; // words buffered toward the link

   // user pattern sequencing
   typedef enum logic {LTPG_UP_ACTIVE, LTPG_UP_ZERO} ltpg_up_t;

endpackage : ltpg_pkg

/* File: ltpg_top.sv */
// ltpg_top: link test pattern generator with its output FIFO.
// assumes register port and data stream share ref_clk; reset is async active low.
//
// How it works
// - low nibble of control picks pattern, zero off
// - bits five to four pick injection point
// - sample point: 16-bit word advances per frame
// - symbol point: 10-bit values, user bits 15:6
// - octet point: 8-bit values, upper user bits
// - checkerboard 5555/AAAA cut to point width
// - word toggle zeros then ones, cut to width
// - PN31 x^31+x^28+1 from its seed
// - PN23 x^23+x^18+1 from its seed
// - PN15 x^15+x^14+1 from its seed
// - PN9 x^9+x^5+1 from its seed
// - PN7 x^7+x^6+1 from its seed
// - ramp wraps at the injection width
// - four user words repeat forever
// - four user words once, then zeros
// - user words come from their byte registers
`timescale 1ns/1ps

// simple synchronous FIFO; in_ready is a flop so back-pressure is glitch free
module ltpg_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   // refuse depths the pointer wrap cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("ltpg_fifo depth must be a power of two of at least two");
   end

   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [AW-1:0] wr_ptr_q; // write index
   logic [AW-1:0] rd_ptr_q; // read index
   logic [CW-1:0] cnt_q; // words held
   logic [CW-1:0] cnt_d;
   logic ready_q; // room for one more word
   wire push = in_valid && ready_q;
   wire pop = out_valid && out_ready;

   assign in_ready = ready_q;
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_ptr_q];
   assign cnt_d = cnt_q + CW'(push) - CW'(pop);

   // storage has no reset; the pointers, count and ready flag carry the state
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   // pointers and the registered ready flag
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
         ready_q <= 1'b0;
      end
      else
      begin
         wr_ptr_q <= wr_ptr_q + AW'(push);
         rd_ptr_q <= rd_ptr_q + AW'(pop);
         cnt_q <= cnt_d;
         ready_q <= (cnt_d < CW'(DEPTH));
      end
   end
endmodule : ltpg_fifo

module ltpg_top #(
   parameter int FIFO_DEPTH = ltpg_pkg::LTPG_FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [ltpg_pkg::LTPG_DATA_W-1:0] in_data,
   input wire logic in_frame_last,
   output logic out_valid,
   input wire logic out_ready,
   output logic [ltpg_pkg::LTPG_DATA_W-1:0] out_data,
   output logic pattern_active
);
   import ltpg_pkg::*;

   // seed, length and tap of the selected sequence
   function automatic logic [40:0] pn_cfg(input logic [3:0] m);
      case (m)
         LTPG_MODE_PN31: pn_cfg = {LTPG_SEED_PN31, LTPG_LEN_PN31, LTPG_TAP_PN31};
         LTPG_MODE_PN23: pn_cfg = {LTPG_SEED_PN23, LTPG_LEN_PN23, LTPG_TAP_PN23};
         LTPG_MODE_PN15: pn_cfg = {LTPG_SEED_PN15, LTPG_LEN_PN15, LTPG_TAP_PN15};
         LTPG_MODE_PN9: pn_cfg = {LTPG_SEED_PN9, LTPG_LEN_PN9, LTPG_TAP_PN9};
         default: pn_cfg = {LTPG_SEED_PN7, LTPG_LEN_PN7, LTPG_TAP_PN7};
      endcase
   endfunction : pn_cfg

   // runs the shift register n steps; oldest bit sits at bit 0, so a seed leaves low bit first
   // returns {next state, bits out MSB first}
   function automatic logic [46:0] pn_run(input logic [30:0] s, input logic [4:0] len,
                                          input logic [4:0] tap, input logic [4:0] n);
      logic [30:0] t;
      logic [15:0] bits;
      t = s;
      bits = '0;
      for (int i = 0; i < 16; i++)
      begin
         if (5'(i) < n)
         begin
            bits = {bits[14:0], t[0]};
            t = (t >> 1) | (31'(t[0] ^ t[len - tap]) << (len - 5'h01));
         end
      end
      pn_run = {t, bits};
   endfunction : pn_run

   logic [7:0] ctrl_q; // control register
   logic [7:0] up_q [LTPG_UP_BYTES]; // user pattern bytes
   logic [7:0] rdata_q; // read data
   logic phase_q; // checker and toggle phase
   logic [15:0] ramp_q; // ramp value
   logic [30:0] pn_q; // shift register
   logic [1:0] up_idx_q; // user word index
   ltpg_up_t up_st_q; // user sequence state
   logic active_q; // pattern generation on
   logic out_valid_q; // output stage full
   logic [15:0] out_data_q; // output stage word

   // register decode
   wire ctrl_hit = (reg_addr == LTPG_ADDR_CTRL);
   wire up_hit = (reg_addr >= LTPG_ADDR_UP_FIRST) && (reg_addr <= LTPG_ADDR_UP_LAST);
   wire [2:0] up_sel = 3'(reg_addr - LTPG_ADDR_UP_FIRST);
   wire ctrl_wr = reg_wr_en && ctrl_hit;
   wire restart = ctrl_wr && (reg_wdata[5:0] != ctrl_q[5:0]);
   wire [3:0] mode = ctrl_q[LTPG_MODE_LSB +: 4];
   wire [1:0] inj = ctrl_q[LTPG_INJ_LSB +: 2];
   wire [3:0] new_mode = reg_wdata[LTPG_MODE_LSB +: 4];
   // injection code 11 is unassigned and leaves the data untouched
   wire gen_on = (mode != LTPG_MODE_OFF) && (inj != 2'h3);

   // width of the injection point and its mask
   wire [4:0] width = (inj == LTPG_INJ_SYMBOL) ? LTPG_W_SYMBOL :
                      (inj == LTPG_INJ_OCTET) ? LTPG_W_OCTET : LTPG_W_SAMPLE;
   wire [15:0] mask = 16'hFFFF >> (5'h10 - width);

   // FIFO handshake and pattern advance
   wire fifo_ready;
   wire accept = in_valid && fifo_ready;
   wire advance = accept && gen_on && ((inj != LTPG_INJ_SAMPLE) || in_frame_last);

   // pseudorandom slice: width new bits per advance, in the low bits, first bit out on top
   wire [40:0] cfg = pn_cfg(mode);
   wire [40:0] new_cfg = pn_cfg(new_mode);
   wire [46:0] pn_res = pn_run(pn_q, cfg[9:5], cfg[4:0], width);
   wire [15:0] pn_word = pn_res[15:0];
   wire is_pn = (mode >= LTPG_MODE_PN31) && (mode <= LTPG_MODE_PN7);

   // user word sliced from its upper bits
   wire [15:0] up_full = {up_q[{up_idx_q, 1'b1}], up_q[{up_idx_q, 1'b0}]};
   wire [15:0] up_word = (inj == LTPG_INJ_SYMBOL) ? (up_full >> LTPG_UP_SYMBOL_LSB) :
                         (inj == LTPG_INJ_OCTET) ? (up_full >> LTPG_UP_OCTET_LSB) : up_full;

   // pattern select, before masking to the point width
   logic [15:0] raw_word;
   always_comb
   begin
      case (mode)
         LTPG_MODE_CHECKER: raw_word = phase_q ? LTPG_CHECK_B : LTPG_CHECK_A;
         LTPG_MODE_TOGGLE: raw_word = phase_q ? LTPG_TOGGLE_HI : 16'h0000;
         LTPG_MODE_RAMP: raw_word = ramp_q;
         LTPG_MODE_UP_REPEAT: raw_word = up_word;
         LTPG_MODE_UP_SINGLE: raw_word = (up_st_q == LTPG_UP_ZERO) ? 16'h0000 : up_word;
         default: raw_word = is_pn ? pn_word : 16'h0000;
      endcase
   end
   wire [15:0] fifo_wdata = gen_on ? (raw_word & mask) : in_data;

   // register writes; control field change is seen by restart above
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q <= LTPG_CTRL_RESET;
         rdata_q <= 8'h00;
         for (int i = 0; i < LTPG_UP_BYTES; i++)
         begin
            up_q[i] <= 8'h00;
         end
      end
      else
      begin
         if (ctrl_wr)
         begin
            ctrl_q <= reg_wdata;
         end
         if (reg_wr_en && up_hit)
         begin
            up_q[up_sel] <= reg_wdata;
         end
         // unmapped addresses read zero
         if (reg_rd_en)
         begin
            rdata_q <= ctrl_hit ? ctrl_q : (up_hit ? up_q[up_sel] : 8'h00);
         end
      end
   end

   // generator state: restart wins over advance so the new mode begins at its seed
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_q <= 1'b0;
         ramp_q <= 16'h0000;
         pn_q <= LTPG_SEED_PN7;
         up_idx_q <= 2'h0;
         up_st_q <= LTPG_UP_ACTIVE;
      end
      else if (restart)
      begin
         phase_q <= 1'b0;
         ramp_q <= 16'h0000;
         pn_q <= new_cfg[40:10];
         up_idx_q <= 2'h0;
         up_st_q <= LTPG_UP_ACTIVE;
      end
      else if (advance)
      begin
         phase_q <= !phase_q;
         ramp_q <= (ramp_q + 16'h0001) & mask;
         pn_q <= pn_res[46:16];
         up_idx_q <= up_idx_q + 2'h1;
         case (up_st_q)
            LTPG_UP_ACTIVE: up_st_q <= (up_idx_q == 2'h3) ? LTPG_UP_ZERO : LTPG_UP_ACTIVE;
            default: up_st_q <= LTPG_UP_ZERO;
         endcase
      end
   end

   // output buffer; the drain side can stall it until in_ready drops
   wire fifo_out_valid;
   wire [15:0] fifo_out_data;
   wire stage_load = fifo_out_valid && (!out_valid_q || out_ready);

   ltpg_fifo #(
      .WIDTH(LTPG_DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(in_valid),
      .in_ready(fifo_ready),
      .in_data(fifo_wdata),
      .out_valid(fifo_out_valid),
      .out_ready(stage_load),
      .out_data(fifo_out_data)
   );

   // output register stage so every port comes from a flop
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_valid_q <= 1'b0;
         out_data_q <= 16'h0000;
         active_q <= 1'b0;
      end
      else
      begin
         if (stage_load)
         begin
            out_valid_q <= 1'b1;
            out_data_q <= fifo_out_data;
         end
         else if (out_ready)
         begin
            out_valid_q <= 1'b0;
         end
         active_q <= gen_on;
      end
   end

   assign in_ready = fifo_ready;
   assign out_valid = out_valid_q;
   assign out_data = out_data_q;
   assign reg_rdata = rdata_q;
   assign pattern_active = active_q;

   // checks on the generator
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_ramp_step;
      advance && !restart && mode == LTPG_MODE_RAMP;
   endsequence

   AST_OFF_PASSES: assert property (accept && mode == LTPG_MODE_OFF |-> fifo_wdata == in_data)
      else $error("data altered with generation off");
   AST_CTRL_WRITE: assert property (ctrl_wr |=> ctrl_q == $past(reg_wdata))
      else $error("control write lost");
   AST_SAMPLE_HOLD: assert property (accept && gen_on && inj == LTPG_INJ_SAMPLE && !in_frame_last
                                     && !restart |=> $stable(pn_q) && $stable(ramp_q))
      else $error("sample pattern moved inside a frame");
   AST_SYMBOL_WIDTH: assert property (accept && gen_on && inj == LTPG_INJ_SYMBOL
                                      |-> fifo_wdata[15:10] == 6'h00)
      else $error("symbol wider than ten bits");
   AST_OCTET_WIDTH: assert property (accept && gen_on && inj == LTPG_INJ_OCTET
                                     |-> fifo_wdata[15:8] == 8'h00)
      else $error("octet wider than eight bits");
   AST_CHECKER_ALT: assert property (accept && mode == LTPG_MODE_CHECKER && inj == LTPG_INJ_SAMPLE
                                     && !phase_q |-> fifo_wdata == LTPG_CHECK_A)
      else $error("checkerboard phase wrong");
   AST_RAMP_STEP: assert property (s_ramp_step |=> ramp_q == (($past(ramp_q) + 16'h0001) & mask))
      else $error("ramp did not step by one");
   AST_UP_WRAP: assert property (advance && !restart && mode == LTPG_MODE_UP_REPEAT && up_idx_q == 2'h3
                                 |=> up_idx_q == 2'h0)
      else $error("user pattern did not wrap");
   AST_UP_ZEROS: assert property (accept && mode == LTPG_MODE_UP_SINGLE && up_st_q == LTPG_UP_ZERO
                                  |-> fifo_wdata == 16'h0000)
      else $error("single user pattern not followed by zeros");
   AST_RESTART_SEED: assert property (restart |=> pn_q == $past(new_cfg[40:10]) && ramp_q == 16'h0000
                                      && up_idx_q == 2'h0)
      else $error("generator not restarted on field change");
   AST_OUT_HOLD: assert property (out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q))
      else $error("output word dropped under stall");
endmodule : ltpg_top

/* File: ltpg_rx_model.sv */
// ltpg_rx_model: far-end receiver that drains the pattern stream into a queue.
// assumes one clock shared with the generator; pace is set by the bench.
`timescale 1ns/1ps

module ltpg_rx_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic out_valid,
   input wire logic [15:0] out_data,
   input wire logic [1:0] pace,
   output logic out_ready
);
   logic tick_q; // toggles every cycle for the slow pace
   logic [15:0] rx_q [$]; // words taken off the link, oldest first

   // pace 0 stalls, 1 takes every cycle, 2 takes every other cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_ready <= 1'b0;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= ~tick_q;
         out_ready <= (pace == 2'h1) | ((pace == 2'h2) & tick_q);
      end
   end

   // a word counts only on an edge where both sides agreed
   always @(posedge clk)
   begin
      if (rst_n && out_valid && out_ready)
         rx_q.push_back(out_data);
   end
endmodule : ltpg_rx_model

/* File: tb_link_test_pattern_generator.sv */
// tb_link_test_pattern_generator: self-checking bench for the link test pattern generator.
// assumes ltpg_pkg, ltpg_top and ltpg_rx_model are compiled before it.
`timescale 1ns/1ps

module tb_link_test_pattern_generator;
   import ltpg_pkg::*;
   logic ref_clk = 1'b0; // 250 MHz converter clock
   logic rst_n = 1'b0; // async reset, active low
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic in_valid = 1'b0;
   logic in_ready;
   logic [15:0] in_data = 16'h0000;
   logic in_frame_last = 1'b0;
   logic out_valid;
   logic out_ready;
   logic [15:0] out_data;
   logic pattern_active;
   logic [1:0] pace = 2'h1; // receiver speed
   int errors = 0;
   int cmp_count = 0;
   int sent = 0; // words accepted by the generator
   logic [15:0] up [4] = '{16'hC35A, 16'h1E96, 16'hA5F0, 16'h7B24}; // user words
   logic [3:0] modes [10] = '{LTPG_MODE_CHECKER, LTPG_MODE_TOGGLE, LTPG_MODE_PN31, LTPG_MODE_PN23,
      LTPG_MODE_PN15, LTPG_MODE_PN9, LTPG_MODE_PN7, LTPG_MODE_RAMP, LTPG_MODE_UP_REPEAT, LTPG_MODE_UP_SINGLE};

   always #2 ref_clk = ~ref_clk;

   ltpg_top #(.FIFO_DEPTH(LTPG_FIFO_DEPTH)) ltpg_top_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
      .in_frame_last(in_frame_last), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .pattern_active(pattern_active));

   ltpg_rx_model ltpg_rx_model_i (.clk(ref_clk), .rst_n(rst_n), .out_valid(out_valid),
      .out_data(out_data), .pace(pace), .out_ready(out_ready));

   // one comparison, counted; mismatches reported at once
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // register write: one-cycle strobe, then one idle edge
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      @(posedge ref_clk);
   endtask : reg_wr

   // register read: data is registered, so look half a cycle after the read edge
   task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
      @(negedge ref_clk);
      check(16'(reg_rdata), 16'(exp), "read");
      @(posedge ref_clk);
   endtask : reg_rd

   // upstream words, frames of four samples; held until taken
   task automatic send(input int n);
      for (int i = 0; i < n; i++)
      begin
         in_valid <= 1'b1;
         in_data <= 16'(i * 7 + 3);
         in_frame_last <= (i % 4 == 3);
         @(posedge ref_clk);
         while (!in_ready)
            @(posedge ref_clk);
         sent++;
      end
      in_valid <= 1'b0;
      in_data <= ~in_data; // released data must not look like the last word
   endtask : send

   // bounded wait for n words at the receiver
   task automatic wait_rx(input int n);
      int t;
      t = 0;
      while (ltpg_rx_model_i.rx_q.size() < n && t < 600)
      begin
         @(posedge ref_clk);
         t++;
      end
      check(16'(ltpg_rx_model_i.rx_q.size()), 16'(n), "count");
   endtask : wait_rx

   // expected word i: pattern index per frame or per unit, cut to the point width
   function automatic logic [15:0] exp_word(input logic [3:0] m, input logic [1:0] inj, input int i);
      int w;
      int p;
      logic [15:0] v;
      logic [30:0] s;
      int ln;
      int tp;
      w = (inj == LTPG_INJ_SYMBOL) ? 10 : (inj == LTPG_INJ_OCTET) ? 8 : 16;
      p = (inj == LTPG_INJ_SAMPLE) ? i / 4 : i;
      v = 16'h0000;
      s = LTPG_SEED_PN7;
      ln = 7;
      tp = 6;
      if (m == LTPG_MODE_PN31) {s, ln, tp} = {LTPG_SEED_PN31, 32'd31, 32'd28};
      if (m == LTPG_MODE_PN23) {s, ln, tp} = {LTPG_SEED_PN23, 32'd23, 32'd18};
      if (m == LTPG_MODE_PN15) {s, ln, tp} = {LTPG_SEED_PN15, 32'd15, 32'd14};
      if (m == LTPG_MODE_PN9) {s, ln, tp} = {LTPG_SEED_PN9, 32'd9, 32'd5};
      // unassigned point 11 leaves the data untouched, whatever the mode
      case ((inj == 2'h3) ? LTPG_MODE_OFF : m)
         LTPG_MODE_OFF: v = 16'(i * 7 + 3); // pass-through
         LTPG_MODE_CHECKER: v = p[0] ? 16'hAAAA : 16'h5555;
         LTPG_MODE_TOGGLE: v = p[0] ? 16'hFFFF : 16'h0000;
         LTPG_MODE_RAMP: v = 16'(p);
         LTPG_MODE_UP_REPEAT: v = up[p % 4] >> (16 - w);
         LTPG_MODE_UP_SINGLE: v = (p < 4) ? up[p % 4] >> (16 - w) : 16'h0000;
         default:
         begin
            // seed leaves low bit first; a[n] = a[n-len] ^ a[n-tap]
            for (int k = 0; k < p * w + w; k++)
            begin
               v = {v[14:0], s[0]};
               s = (s >> 1) | (31'(s[0] ^ s[ln - tp]) << (ln - 1));
            end
         end
      endcase
      return v & 16'((32'h1 << w) - 1);
   endfunction : exp_word

   // set mode and point, stream n words, compare every one received
   task automatic run_pat(input logic [3:0] m, input logic [1:0] inj, input int n);
      ltpg_rx_model_i.rx_q.delete();
      reg_wr(LTPG_ADDR_CTRL, {2'b00, inj, m});
      @(negedge ref_clk);
      check(16'(pattern_active), 16'(m != LTPG_MODE_OFF && inj != 2'h3), "active");
      @(posedge ref_clk);
      send(n);
      wait_rx(n);
      for (int i = 0; i < n; i++)
         check(ltpg_rx_model_i.rx_q[i], exp_word(m, inj, i), $sformatf("m%h p%0d w%0d", m, inj, i));
   endtask : run_pat

   // reset values, user bytes, readback, unmapped place
   task automatic t_regs;
      reg_rd(LTPG_ADDR_CTRL, 8'h00);
      reg_rd(LTPG_ADDR_UP_FIRST, 8'h00);
      for (int k = 0; k < 4; k++)
      begin
         reg_wr(LTPG_ADDR_UP_FIRST + 16'(2 * k), up[k][7:0]);
         reg_wr(LTPG_ADDR_UP_FIRST + 16'(2 * k + 1), up[k][15:8]);
      end
      reg_rd(LTPG_ADDR_UP_LAST, up[3][15:8]);
      reg_wr(LTPG_ADDR_CTRL, 8'h2E);
      reg_wr(16'h0560, 8'h5A);
      reg_rd(16'h0560, 8'h00);
      reg_rd(LTPG_ADDR_CTRL, 8'h2E);
      $display("test regs done");
   endtask : t_regs

   // every mode but off at every assigned point; symbol and octet against a slow receiver
   task automatic t_all_modes;
      for (int j = 0; j < 3; j++)
      begin
         pace <= (j == 0) ? 2'h1 : 2'h2;
         for (int k = 0; k < 10; k++)
            run_pat(modes[k], 2'(j), (j == 0) ? 20 : 12);
      end
      $display("test all modes done");
   endtask : t_all_modes

   // same mode, new point: generator must start again from its seed; unassigned point passes data
   task automatic t_restart;
      run_pat(LTPG_MODE_PN7, LTPG_INJ_SYMBOL, 6);
      run_pat(LTPG_MODE_PN7, LTPG_INJ_OCTET, 6);
      run_pat(LTPG_MODE_RAMP, LTPG_INJ_OCTET, 300);
      run_pat(LTPG_MODE_CHECKER, 2'h3, 8);
      $display("test restart done");
   endtask : t_restart

   // receiver stalls until the buffer refuses, then drains slowly
   task automatic t_fifo;
      reg_wr(LTPG_ADDR_CTRL, 8'h00);
      ltpg_rx_model_i.rx_q.delete();
      pace <= 2'h0;
      sent = 0;
      fork
         send(24);
      join_none
      repeat (60) @(posedge ref_clk);
      check(16'(in_ready), 16'h0000, "full");
      check(16'(sent >= LTPG_FIFO_DEPTH && sent <= LTPG_FIFO_DEPTH + 2), 16'h0001, "fill");
      pace <= 2'h2;
      wait_rx(24);
      for (int i = 0; i < 24; i++)
         check(ltpg_rx_model_i.rx_q[i], exp_word(LTPG_MODE_OFF, LTPG_INJ_SAMPLE, i), "order");
      pace <= 2'h1;
      $display("test fifo done");
   endtask : t_fifo

   // leave test mode the way software must, then data passes untouched
   task automatic t_exit;
      reg_wr(16'h0000, 8'h81);
      run_pat(LTPG_MODE_OFF, LTPG_INJ_SAMPLE, 8);
      $display("test exit done");
   endtask : t_exit

   // counts, verdict, end of run
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   // main sequence
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      t_regs();
      t_all_modes();
      t_restart();
      t_fifo();
      t_exit();
      close_out();
   end

   // watchdog: the tests need well under 10000 cycles
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      errors++;
      close_out();
   end
endmodule : tb_link_test_pattern_generator
